// ---- rtl/pbpd_ctrl.sv ----
// pbpd_ctrl: posted i/o write match, write-buffer flush ahead of special
// cycles, and delayed-transaction retry / abort control.
// assumes one clock; host, pci and buffer strobes are synchronous to it.
`timescale 1ns/1ps
module pbpd_ctrl #(
	parameter int LAT_CLKS = pbpd_pkg::DT_LATENCY_CLKS
) (
	// clock and reset
	input  wire logic                    clk_in,
	input  wire logic                    reset_in,
	// configuration access
	input  wire pbpd_pkg::pbpd_cfg_req_t cfg_in,
	output logic [7:0]                   cfg_rdata_out,
	// host i/o write
	input  wire pbpd_pkg::pbpd_io_wr_t   io_wr_in,
	output logic                         io_post_out,
	output logic [3:0]                   io_post_be_out,
	// special cycle requests toward pci master
	input  wire logic                    cyc_req_in,
	input  wire pbpd_pkg::pbpd_cyc_t     cyc_type_in,
	input  wire logic                    mwb_empty_in,
	output logic                         mwb_flush_out,
	output logic                         cyc_issue_out,
	output pbpd_pkg::pbpd_cyc_t          cyc_issue_type_out,
	// pci target side delayed transactions
	input  wire pbpd_pkg::pbpd_tgt_req_t tgt_in,
	input  wire logic                    int_done_in,
	output logic                         tgt_retry_out,
	output logic                         tgt_complete_out,
	output logic                         int_start_out,
	output logic                         dt_abort_out
);
	import pbpd_pkg::*;

	logic [15:0] post_addr_q [NUM_POST];
	logic [7:0]  post_ctrl_q;
	logic [7:0]  flush_ctrl_q;
	logic [7:0]  abort_limit_q;

	function automatic logic [7:0] post_ofs(input int i);
		post_ofs = OFS_POST_ADDR1 + 8'(2 * i);
	endfunction

	// configuration registers, byte writes at printed indices
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			for (int i = 0; i < NUM_POST; i++) begin
				post_addr_q[i] <= RST_POST_ADDR;
			end
			post_ctrl_q   <= RST_POST_CTRL;
			flush_ctrl_q  <= RST_FLUSH_CTRL;
			abort_limit_q <= RST_ABORT_LIMIT;
		end else if (cfg_in.wr) begin
			for (int i = 0; i < NUM_POST; i++) begin
				if (cfg_in.addr == post_ofs(i)) begin
					post_addr_q[i][7:0] <= cfg_in.wdata;
				end
				if (cfg_in.addr == post_ofs(i) + 8'h01) begin
					post_addr_q[i][15:8] <= cfg_in.wdata;
				end
			end
			if (cfg_in.addr == OFS_POST_CTRL) begin
				post_ctrl_q <= cfg_in.wdata;
			end
			if (cfg_in.addr == OFS_FLUSH_CTRL) begin
				flush_ctrl_q <= {FLUSH_RSVD_MASK, cfg_in.wdata[3:0]};
			end
			if (cfg_in.addr == OFS_ABORT_LIMIT) begin
				abort_limit_q <= cfg_in.wdata;
			end
		end
	end

	logic [7:0] rd_d;
	always_comb begin
		rd_d = 8'h00;
		for (int i = 0; i < NUM_POST; i++) begin
			if (cfg_in.addr == post_ofs(i)) begin
				rd_d = post_addr_q[i][7:0];
			end
			if (cfg_in.addr == post_ofs(i) + 8'h01) begin
				rd_d = post_addr_q[i][15:8];
			end
		end
		if (cfg_in.addr == OFS_POST_CTRL) begin
			rd_d = post_ctrl_q;
		end
		if (cfg_in.addr == OFS_FLUSH_CTRL) begin
			rd_d = flush_ctrl_q;
		end
		if (cfg_in.addr == OFS_ABORT_LIMIT) begin
			rd_d = abort_limit_q;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			cfg_rdata_out <= 8'h00;
		end else if (cfg_in.rd) begin
			cfg_rdata_out <= rd_d;
		end
	end

	// posting match: one comparator per address, results or-ed per byte
	logic [3:0] hit_be [NUM_POST];
	genvar g;
	generate
		for (g = 0; g < NUM_POST; g++) begin : g_match
			logic [1:0] lane;
			logic [3:0] run;
			assign lane = post_addr_q[g][1:0];
			// starting lane and every enabled lane above it without a gap
			always_comb begin
				run = 4'h0;
				if (io_wr_in.be[lane]) begin
					run[lane] = 1'b1;
					for (int b = 1; b < 4; b++) begin
						if (b > int'(lane) && run[b - 1] && io_wr_in.be[b]) begin
							run[b] = 1'b1;
						end
					end
				end
			end
			always_comb begin
				hit_be[g] = 4'h0;
				if (io_wr_in.valid && post_ctrl_q[2 * g]
					&& io_wr_in.addr[15:2] == post_addr_q[g][15:2]) begin
					if (post_ctrl_q[2 * g + 1]) begin
						hit_be[g] = run;
					end else begin
						hit_be[g] = 4'(io_wr_in.be & (4'h1 << lane));
					end
				end
			end
		end
	endgenerate

	logic [3:0] post_be_d;
	always_comb begin
		post_be_d = 4'h0;
		for (int i = 0; i < NUM_POST; i++) begin
			post_be_d = post_be_d | hit_be[i];
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			io_post_out    <= 1'b0;
			io_post_be_out <= 4'h0;
		end else begin
			io_post_out    <= |post_be_d;
			io_post_be_out <= post_be_d;
		end
	end

	// flush-before-issue sequencer
	typedef enum logic [1:0] {SQ_IDLE, SQ_FLUSH, SQ_ISSUE} pbpd_seq_t;
	pbpd_seq_t seq_q;
	pbpd_cyc_t pend_q;
	logic      need_flush;
	always_comb begin
		unique case (cyc_type_in)
			CYC_CONFIG: need_flush = flush_ctrl_q[FLUSH_CFG_BIT];
			CYC_STPGNT: need_flush = flush_ctrl_q[FLUSH_STPGNT_BIT];
			CYC_HALT:   need_flush = flush_ctrl_q[FLUSH_HALT_BIT];
			CYC_SHUT:   need_flush = flush_ctrl_q[FLUSH_SHUT_BIT];
		endcase
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			seq_q              <= SQ_IDLE;
			pend_q             <= CYC_CONFIG;
			mwb_flush_out      <= 1'b0;
			cyc_issue_out      <= 1'b0;
			cyc_issue_type_out <= CYC_CONFIG;
		end else begin
			cyc_issue_out <= 1'b0;
			unique case (seq_q)
				SQ_IDLE: begin
					if (cyc_req_in) begin
						pend_q <= cyc_type_in;
						if (need_flush) begin
							seq_q         <= SQ_FLUSH;
							mwb_flush_out <= 1'b1;
						end else begin
							cyc_issue_out      <= 1'b1;
							cyc_issue_type_out <= cyc_type_in;
						end
					end
				end
				SQ_FLUSH: begin
					if (mwb_empty_in) begin
						mwb_flush_out <= 1'b0;
						seq_q         <= SQ_ISSUE;
					end
				end
				SQ_ISSUE: begin
					cyc_issue_out      <= 1'b1;
					cyc_issue_type_out <= pend_q;
					seq_q              <= SQ_IDLE;
				end
				default: begin
					seq_q <= SQ_IDLE;
				end
			endcase
		end
	end

	// delayed transaction tracking
	logic        dt_busy_q;
	logic        dt_done_q;
	logic [3:0]  dt_master_q;
	logic [26:0] dt_line_q;
	logic        dt_read_q;
	logic [7:0]  miss_cnt_q;
	logic        same_m, same_l, limit_hit;
	assign same_m    = tgt_in.master == dt_master_q;
	assign same_l    = tgt_in.line == dt_line_q;
	assign limit_hit = (miss_cnt_q + 8'h01) == abort_limit_q;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			dt_busy_q        <= 1'b0;
			dt_done_q        <= 1'b0;
			dt_master_q      <= 4'h0;
			dt_line_q        <= 27'h0;
			dt_read_q        <= 1'b0;
			miss_cnt_q       <= 8'h00;
			tgt_retry_out    <= 1'b0;
			tgt_complete_out <= 1'b0;
			int_start_out    <= 1'b0;
			dt_abort_out     <= 1'b0;
		end else begin
			tgt_retry_out    <= 1'b0;
			tgt_complete_out <= 1'b0;
			int_start_out    <= 1'b0;
			dt_abort_out     <= 1'b0;
			if (int_done_in && dt_busy_q) begin
				dt_done_q <= 1'b1;
			end
			if (tgt_in.valid) begin
				if (!dt_busy_q) begin
					// target latency is always over the limit, so start delayed
					tgt_retry_out <= 1'b1;
					int_start_out <= 1'b1;
					dt_busy_q     <= 1'b1;
					dt_done_q     <= 1'b0;
					dt_master_q   <= tgt_in.master;
					dt_line_q     <= tgt_in.line;
					dt_read_q     <= tgt_in.is_read;
					miss_cnt_q    <= 8'h00;
				end else if (same_m && same_l) begin
					if (dt_done_q || int_done_in) begin
						tgt_complete_out <= 1'b1;
						dt_busy_q        <= 1'b0;
						dt_done_q        <= 1'b0;
					end else begin
						tgt_retry_out <= 1'b1;
					end
				end else if (same_m && dt_read_q) begin
					tgt_retry_out <= 1'b1;
					if (limit_hit) begin
						dt_abort_out  <= 1'b1;
						int_start_out <= 1'b1;
						dt_done_q     <= 1'b0;
						dt_line_q     <= tgt_in.line;
						dt_read_q     <= tgt_in.is_read;
						miss_cnt_q    <= 8'h00;
					end else begin
						miss_cnt_q <= miss_cnt_q + 8'h01;
					end
				end else begin
					tgt_retry_out <= 1'b1;
				end
			end
		end
	end

	// checks
	exact_byte_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(io_wr_in.valid && post_ctrl_q[6] && !post_ctrl_q[7]
		 && io_wr_in.addr[15:2] == post_addr_q[3][15:2]
		 && post_ctrl_q[5:0] == 6'h00)
		|=> (io_post_be_out & ~(4'h1 << $past(post_addr_q[3][1:0]))) == 4'h0)
		else $error("exact mode posted a neighbouring byte");
	post_disabled_a: assert property (@(posedge clk_in) disable iff (reset_in)
		($past(post_ctrl_q[0]) == 1'b0 && $past(post_ctrl_q[2]) == 1'b0
		 && $past(post_ctrl_q[4]) == 1'b0 && $past(post_ctrl_q[6]) == 1'b0)
		|-> !io_post_out)
		else $error("post with every enable clear");
	below_start_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(post_ctrl_q == 8'hc0 && io_wr_in.valid)
		|=> (io_post_be_out & ((4'h1 << $past(post_addr_q[3][1:0])) - 4'h1)) == 4'h0)
		else $error("byte below start address posted");
	flush_wait_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(seq_q == SQ_FLUSH && !mwb_empty_in) |=> !cyc_issue_out)
		else $error("cycle issued before buffer empty");
	no_flush_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(seq_q == SQ_IDLE && cyc_req_in && !need_flush)
		|=> cyc_issue_out && !mwb_flush_out)
		else $error("unflushed cycle not issued at once");
	flush_issue_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(seq_q == SQ_FLUSH && mwb_empty_in) |=> ##1 cyc_issue_out)
		else $error("cycle not issued after buffer emptied");
	flush_start_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(seq_q == SQ_IDLE && cyc_req_in && need_flush) |=> mwb_flush_out && !cyc_issue_out)
		else $error("flush not requested");
	first_retry_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(tgt_in.valid && !dt_busy_q) |=> tgt_retry_out && int_start_out)
		else $error("new cycle not retried and started");
	complete_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(tgt_in.valid && dt_busy_q && same_m && same_l && dt_done_q)
		|=> tgt_complete_out && !tgt_retry_out)
		else $error("finished delayed cycle not completed");
	abort_limit_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(tgt_in.valid && dt_busy_q && same_m && !same_l && dt_read_q && limit_hit)
		|=> dt_abort_out && int_start_out && tgt_retry_out)
		else $error("abort missing at limit");
endmodule

// ---- rtl/pbpd_pkg.sv ----
// pbpd_pkg: configuration offsets, field positions, resets and carrier types
// for the bridge's posting, flush and delayed-transaction control.
// assumes byte-wide configuration access at the printed indices.
package pbpd_pkg;
	localparam logic [7:0]  OFS_POST_ADDR1      = 8'h42;
	localparam logic [7:0]  OFS_POST_ADDR2      = 8'h44;
	localparam logic [7:0]  OFS_POST_ADDR3      = 8'h46;
	localparam logic [7:0]  OFS_POST_ADDR4      = 8'h48;
	localparam logic [7:0]  OFS_POST_CTRL       = 8'h4a;
	localparam logic [7:0]  OFS_FLUSH_CTRL      = 8'h4b;
	localparam logic [7:0]  OFS_ABORT_LIMIT     = 8'h4c;
	localparam logic [15:0] RST_POST_ADDR       = 16'h0000;
	localparam logic [7:0]  RST_POST_CTRL       = 8'h00;
	localparam logic [7:0]  RST_FLUSH_CTRL      = 8'h00;
	localparam logic [7:0]  RST_ABORT_LIMIT     = 8'h04;
	localparam int          FLUSH_CFG_BIT       = 3;
	localparam int          FLUSH_STPGNT_BIT    = 2;
	localparam int          FLUSH_HALT_BIT      = 1;
	localparam int          FLUSH_SHUT_BIT      = 0;
	localparam logic [3:0]  FLUSH_RSVD_MASK     = 4'h0;
	localparam int          NUM_POST            = 4;
	localparam int          DT_LATENCY_CLKS     = 8;

	typedef enum logic [1:0] {CYC_CONFIG, CYC_STPGNT, CYC_HALT, CYC_SHUT} pbpd_cyc_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [7:0]  wdata;
	} pbpd_cfg_req_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
		logic [3:0]  be;
	} pbpd_io_wr_t;

	typedef struct packed {
		logic        valid;
		logic [3:0]  master;
		logic [26:0] line;
		logic        is_read;
	} pbpd_tgt_req_t;
endpackage

// ---- verification/pbpd_far_model.sv ----
// pbpd_far_model: write buffer and internal-cycle engine behind the bridge.
// assumes the bench pulses fill_in to load the buffer before a flush test.
`timescale 1ns/1ps
module pbpd_far_model #(
	parameter int DRAIN_CLKS = 5,
	parameter int DONE_CLKS  = 12
) (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic reset_in,
	// bridge side
	input  wire logic fill_in,
	input  wire logic mwb_flush_in,
	input  wire logic int_start_in,
	output logic      mwb_empty_out,
	output logic      int_done_out
);
	logic [7:0] drain_q;
	logic [7:0] done_q;
	logic       full_q;
	assign mwb_empty_out = !full_q;
	// buffer empties only under a flush, never on its own
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			full_q  <= 1'b0;
			drain_q <= 8'h00;
		end else if (fill_in) begin
			full_q  <= 1'b1;
			drain_q <= 8'(DRAIN_CLKS);
		end else if (full_q && mwb_flush_in) begin
			full_q  <= (drain_q != 8'h01);
			drain_q <= drain_q - 8'h01;
		end
	end
	// a restart reloads the count, so an aborted cycle never reports done
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			done_q       <= 8'h00;
			int_done_out <= 1'b0;
		end else begin
			done_q       <= int_start_in ? 8'(DONE_CLKS) : done_q - 8'(done_q != 8'h00);
			int_done_out <= (done_q == 8'h01) && !int_start_in;
		end
	end
endmodule

// ---- verification/pbpd_ctrl_bench.sv ----
// pbpd_ctrl_bench: register, posting, flush and delayed-transaction tests.
// assumes the far model stands in for the write buffer and internal cycles.
`timescale 1ns/1ps
module pbpd_ctrl_bench;
	import pbpd_pkg::*;
	localparam int DRAIN = 5;
	localparam int DONE  = 12;
	logic          clk_in;
	logic          reset_in;
	pbpd_cfg_req_t cfg;
	pbpd_io_wr_t   io_wr;
	pbpd_tgt_req_t tgt;
	pbpd_cyc_t     cyc_type;
	pbpd_cyc_t     issue_type;
	logic          cyc_req;
	logic          fill;
	logic          int_done;
	logic          mwb_empty;
	logic [7:0]    rdata;
	logic [3:0]    post_be;
	logic          post;
	logic          flush;
	logic          issue;
	logic          retry;
	logic          complete;
	logic          start;
	logic          abort;
	logic          tgt_rd = 1'b1;
	int            n_fail = 0;
	int            checks_done = 0;
	int            cycles = 0;
	int            n;

	pbpd_ctrl dut (.clk_in(clk_in), .reset_in(reset_in), .cfg_in(cfg), .cfg_rdata_out(rdata),
		.io_wr_in(io_wr), .io_post_out(post), .io_post_be_out(post_be), .cyc_req_in(cyc_req),
		.cyc_type_in(cyc_type), .mwb_empty_in(mwb_empty), .mwb_flush_out(flush),
		.cyc_issue_out(issue), .cyc_issue_type_out(issue_type), .tgt_in(tgt),
		.int_done_in(int_done), .tgt_retry_out(retry), .tgt_complete_out(complete),
		.int_start_out(start), .dt_abort_out(abort));
	pbpd_far_model #(.DRAIN_CLKS(DRAIN), .DONE_CLKS(DONE)) far (.clk_in(clk_in),
		.reset_in(reset_in), .fill_in(fill), .mwb_flush_in(flush), .int_start_in(start),
		.mwb_empty_out(mwb_empty), .int_done_out(int_done));

	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			end_sim();
		end
	end

	// every task idles one cycle so a strobe never toggles twice in one step
	task automatic cfg_op(input logic w, input logic [7:0] a, input logic [7:0] d);
		cfg = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge clk_in);
		cfg = '0;
		if (!w) check(rdata, d);
		@(negedge clk_in);
	endtask

	task automatic io(input logic [15:0] a, input logic [3:0] be, input logic [4:0] e);
		io_wr = '{valid: 1'b1, addr: a, be: be};
		@(negedge clk_in);
		io_wr.valid = 1'b0;
		check({post, post_be}, e);
		@(negedge clk_in);
	endtask

	task automatic pci(input logic [3:0] m, input logic [26:0] l, input logic [3:0] e);
		tgt = '{valid: 1'b1, master: m, line: l, is_read: tgt_rd};
		@(negedge clk_in);
		tgt.valid = 1'b0;
		check({retry, complete, start, abort}, e);
		@(negedge clk_in);
	endtask

	task automatic special(input int t, input logic fl);
		fill = 1'b1;
		@(negedge clk_in);
		fill = 1'b0;
		cfg_op(1'b1, OFS_FLUSH_CTRL, fl ? 8'h08 >> t : 8'h00);
		cyc_req = 1'b1;
		cyc_type = pbpd_cyc_t'(t);
		@(negedge clk_in);
		cyc_req = 1'b0;
		check({flush, issue}, fl ? 2'b10 : 2'b01);
		n = 0;
		while (issue !== 1'b1 && n < 40) begin
			@(negedge clk_in);
			n++;
		end
		check({mwb_empty | !fl, flush, n >= (fl ? DRAIN : 0), issue_type}, {3'b101, 2'(t)});
		@(negedge clk_in);
	endtask

	initial begin
		reset_in = 1'b1;
		cfg = '0;
		io_wr = '0;
		tgt = '0;
		cyc_req = 1'b0;
		cyc_type = CYC_CONFIG;
		fill = 1'b0;
		repeat (16) @(negedge clk_in);
		reset_in = 1'b0;
		@(negedge clk_in);
		for (int a = 8'h42; a <= 8'h4d; a++) begin
			cfg_op(1'b0, 8'(a), 8'(a == 8'h4c ? 4 : 0));
		end
		for (int a = 8'h42; a <= 8'h4d; a++) begin
			cfg_op(1'b1, 8'(a), 8'(a) ^ 8'h5a);
		end
		for (int a = 8'h42; a <= 8'h4d; a++) begin
			cfg_op(1'b0, 8'(a), a > 8'h4c ? 8'h00 :
				a == 8'h4b ? 8'h01 : 8'(a) ^ 8'h5a);
		end
		cfg_op(1'b1, OFS_ABORT_LIMIT, RST_ABORT_LIMIT);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			cfg_op(1'b1, OFS_POST_ADDR1 + 8'(2 * i), 8'h01 + 8'(i << 4));
			cfg_op(1'b1, OFS_POST_ADDR1 + 8'(2 * i + 1), 8'h03);
			cfg_op(1'b1, OFS_POST_CTRL, 8'h03 << (2 * i));
			io(16'h0300 + 16'(i << 4), 4'hf, 5'h1e);
			io(16'h0300 + 16'(i << 4), 4'hb, 5'h12);
			io(16'h0304 + 16'(i << 4), 4'hf, 5'h00);
			cfg_op(1'b1, OFS_POST_CTRL, 8'h01 << (2 * i));
			io(16'h0300 + 16'(i << 4), 4'hf, 5'h12);
			io(16'h0300 + 16'(i << 4), 4'hd, 5'h00);
			cfg_op(1'b1, OFS_POST_CTRL, 8'h02 << (2 * i));
			io(16'h0300 + 16'(i << 4), 4'hf, 5'h00);
		end
		// two exact-byte addresses in one dword: their lanes must merge
		cfg_op(1'b1, OFS_POST_ADDR1, 8'h02);
		cfg_op(1'b1, OFS_POST_ADDR2, 8'h03);
		cfg_op(1'b1, OFS_POST_CTRL, 8'h05);
		io(16'h0300, 4'hf, 5'h1c);
		cfg_op(1'b1, OFS_POST_CTRL, 8'h00);
		$display("test posting done");
		for (int t = 0; t < 4; t++) begin
			special(t, 1'b0);
			special(t, 1'b1);
		end
		$display("test flush done");
		pci(4'h1, 27'h10, 4'ha);
		pci(4'h1, 27'h10, 4'h8);
		repeat (DONE) @(negedge clk_in);
		pci(4'h1, 27'h10, 4'h4);
		pci(4'h1, 27'h20, 4'ha);
		for (int k = 1; k < 4; k++) pci(4'h1, 27'h20 + 27'(k), 4'h8);
		pci(4'h1, 27'h30, 4'hb);
		pci(4'h2, 27'h30, 4'h8);
		repeat (DONE) @(negedge clk_in);
		pci(4'h1, 27'h30, 4'h4);
		// outstanding write: other lines are retried but never counted
		tgt_rd = 1'b0;
		pci(4'h3, 27'h40, 4'ha);
		for (int k = 1; k < 5; k++) pci(4'h3, 27'h40 + 27'(k), 4'h8);
		repeat (DONE) @(negedge clk_in);
		pci(4'h3, 27'h40, 4'h4);
		$display("test delayed done");
		end_sim();
	end
endmodule
